// *** pkg/smt_pkg.sv ***
/*
  package for the link target management command decoder: register
  indices, command codes, reset-control encodings and timing constants.
  assumes nothing of its surroundings.
*/
`default_nettype none
package smt_pkg;
  localparam logic [7:0] REG_MGMT_COMMAND = 8'h00;
  localparam logic [7:0] REG_MSG_BYTE_LOW = 8'h04;
  localparam logic [7:0] REG_MSG_BYTE_HIGH = 8'h05;

  localparam logic [7:0] CMD_WAKE_OR_SMI = 8'h01;
  localparam logic [7:0] CMD_POWER_DOWN = 8'h02;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h03;
  localparam logic [7:0] CMD_HARD_RESET = 8'h04;
  localparam logic [7:0] CMD_MSG_DISABLE = 8'h05;
  localparam logic [7:0] CMD_WATCHDOG_RELOAD_COMMAND = 8'h06;
  localparam logic [7:0] CMD_LINK_SMI = 8'h08;

  // reset_control_port equivalent values, bits 3:1
  localparam logic [3:0] RST_CTRL_SOFT = 4'h6;
  localparam logic [3:0] RST_CTRL_HARD = 4'hE;

  localparam logic [2:0] PWR_STATE_S0 = 3'h0;
  localparam logic [6:0] TARGET_ADDR_RESET = 7'h44;
  localparam logic [7:0] MSG_BYTE_RESET = 8'h00;
  localparam logic [1:0] SYNC_STAGES = 2'h2;
endpackage
`default_nettype wire

// *** logic/smt_sync.sv ***
/*
  two-flop synchroniser for a bundle of asynchronous levels.
  assumes the inputs come from outside the i_sys_clk domain.
*/
`timescale 1ns/1ns
`default_nettype none
module smt_sync #(
  parameter int WIDTH = 3
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1) begin : g_width_check
    $error("smt_sync needs WIDTH of at least 1");
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= '1;
      o_sync <= '1;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** logic/smt_target.sv ***
/*
  link target management command decoder: a byte-level two-wire target
  that takes byte writes to the command and message registers and answers
  byte reads, and turns commands into one-cycle action pulses, save code 5, which clears a messaging enable level.
  assumes scl and sda are open-drain pins from the initiator, sampled by
  i_sys_clk; read data come combinationally from i_read_data.
*/
// Behaviour
// - register index 0 is the command register
// - index 4 and 5 hold message bytes
// - code 1 wakes asleep system, else interrupt
// - code 2 sets override status, powers down
// - code 3 soft reset, port bits 2:1
// - code 4 hard reset, port bits 3:1
// - code 5 disables messages until resume reset
// - code 6 reloads the watchdog
// - code 8 sets link status only in S0
// - start, matching address, write bit zero
// - target drives selected data byte
`timescale 1ns/1ns
`default_nettype none
module smt_target
  import smt_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_RESET
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_resume_well_reset_b,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe_b,
  input wire logic [2:0] i_power_state,
  input wire logic [7:0] i_read_data,
  output logic [7:0] o_read_index,
  output logic [7:0] o_message_byte_low,
  output logic [7:0] o_message_byte_high,
  output logic o_wake,
  output logic o_system_management_interrupt,
  output logic o_power_button_override_status,
  output logic o_power_down,
  output logic o_reset_port_write,
  output logic [3:0] o_reset_port_bits,
  output logic o_management_messaging_en,
  output logic o_watchdog_reload_command,
  output logic o_link_target_interrupt_status,
  output logic o_link_target_interrupt_command
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_CMD = 6'h04,
    ST_DATA = 6'h08,
    ST_SEND = 6'h10,
    ST_ACK = 6'h20
  } smt_state_t;

  logic [2:0] sync_w;
  logic scl_r;
  logic sda_r;
  logic scl_d_r;
  logic sda_d_r;
  logic rsm_b_w;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  smt_state_t state_r;
  smt_state_t after_ack_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] index_r;
  logic is_read_r;
  logic ack_drive_r;
  logic wr_strobe;
  logic [7:0] wr_data;
  logic awake;

  smt_sync #(.WIDTH(3)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_async({i_resume_well_reset_b, i_sda, i_scl}),
    .o_sync(sync_w)
  );

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= sync_w[0];
      sda_d_r <= sync_w[1];
    end
  end
  assign scl_r = sync_w[0];
  assign sda_r = sync_w[1];
  assign rsm_b_w = sync_w[2];
  assign scl_rise = scl_r && !scl_d_r;
  assign scl_fall = !scl_r && scl_d_r;
  assign start_cond = scl_r && scl_d_r && !sda_r && sda_d_r;
  assign stop_cond = scl_r && scl_d_r && sda_r && !sda_d_r;
  assign awake = (i_power_state == PWR_STATE_S0);

  // byte-level bit engine; repeated start re-enters address phase
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
      after_ack_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      index_r <= 8'h00;
      is_read_r <= 1'b0;
      ack_drive_r <= 1'b0;
    end else if (start_cond) begin
      state_r <= ST_ADDR;
      bit_cnt_r <= 4'h0;
      ack_drive_r <= 1'b0;
    end else if (stop_cond) begin
      state_r <= ST_IDLE;
      ack_drive_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          ack_drive_r <= 1'b0;
        end
        ST_ADDR, ST_CMD, ST_DATA: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            bit_cnt_r <= 4'h0;
            if (state_r == ST_ADDR) begin
              if (shift_r[7:1] == TARGET_ADDR) begin
                ack_drive_r <= 1'b1;
                is_read_r <= shift_r[0];
                after_ack_r <= shift_r[0] ? ST_SEND : ST_CMD;
                state_r <= ST_ACK;
              end else begin
                state_r <= ST_IDLE;
              end
            end else if (state_r == ST_CMD) begin
              index_r <= shift_r;
              ack_drive_r <= 1'b1;
              after_ack_r <= ST_DATA;
              state_r <= ST_ACK;
            end else begin
              ack_drive_r <= 1'b1;
              after_ack_r <= ST_IDLE;
              state_r <= ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            ack_drive_r <= 1'b0;
            state_r <= after_ack_r;
            if (after_ack_r == ST_SEND) begin
              shift_r <= i_read_data;
              ack_drive_r <= !i_read_data[7];
            end
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            if (bit_cnt_r == 4'h7) begin
              ack_drive_r <= 1'b0;
              state_r <= ST_IDLE;
              bit_cnt_r <= 4'h0;
            end else begin
              shift_r <= {shift_r[6:0], 1'b0};
              ack_drive_r <= !shift_r[6];
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // write of the data byte completes on the ack edge of the third byte
  assign wr_strobe = (state_r == ST_DATA) && !start_cond && !stop_cond &&
                     scl_fall && (bit_cnt_r == 4'h8) && !is_read_r;
  assign wr_data = shift_r;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sda_oe_b <= 1'b1;
      o_read_index <= 8'h00;
    end else begin
      o_sda_oe_b <= !ack_drive_r;
      o_read_index <= index_r;
    end
  end

  // no guard against a processor read racing the overwrite
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_message_byte_low <= MSG_BYTE_RESET;
      o_message_byte_high <= MSG_BYTE_RESET;
    end else if (wr_strobe) begin
      if (index_r == REG_MSG_BYTE_LOW) begin
        o_message_byte_low <= wr_data;
      end
      if (index_r == REG_MSG_BYTE_HIGH) begin
        o_message_byte_high <= wr_data;
      end
    end
  end

  // action pulses; other codes and indices fall through untouched
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wake <= 1'b0;
      o_system_management_interrupt <= 1'b0;
      o_power_down <= 1'b0;
      o_reset_port_write <= 1'b0;
      o_reset_port_bits <= 4'h0;
      o_watchdog_reload_command <= 1'b0;
      o_link_target_interrupt_command <= 1'b0;
    end else begin
      o_wake <= 1'b0;
      o_system_management_interrupt <= 1'b0;
      o_power_down <= 1'b0;
      o_reset_port_write <= 1'b0;
      o_watchdog_reload_command <= 1'b0;
      o_link_target_interrupt_command <= 1'b0;
      if (wr_strobe && index_r == REG_MGMT_COMMAND) begin
        case (wr_data)
          CMD_WAKE_OR_SMI: begin
            o_wake <= !awake;
            o_system_management_interrupt <= awake;
          end
          CMD_POWER_DOWN: begin
            o_power_down <= 1'b1;
          end
          CMD_SOFT_RESET: begin
            o_reset_port_write <= 1'b1;
            o_reset_port_bits <= RST_CTRL_SOFT;
          end
          CMD_HARD_RESET: begin
            o_reset_port_write <= 1'b1;
            o_reset_port_bits <= RST_CTRL_HARD;
          end
          CMD_WATCHDOG_RELOAD_COMMAND: begin
            o_watchdog_reload_command <= 1'b1;
          end
          CMD_LINK_SMI: begin
            o_link_target_interrupt_command <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // sticky status bits; only a system reset clears them here
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_power_button_override_status <= 1'b0;
      o_link_target_interrupt_status <= 1'b0;
    end else if (wr_strobe && index_r == REG_MGMT_COMMAND) begin
      if (wr_data == CMD_POWER_DOWN) begin
        o_power_button_override_status <= 1'b1;
      end
      if (wr_data == CMD_LINK_SMI && awake) begin
        o_link_target_interrupt_status <= 1'b1;
      end
    end
  end

  // message disable survives everything except the resume-well reset and the system reset
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_management_messaging_en <= 1'b1;
    end else if (!rsm_b_w) begin
      o_management_messaging_en <= 1'b1;
    end else if (wr_strobe && index_r == REG_MGMT_COMMAND &&
                 wr_data == CMD_MSG_DISABLE) begin
      o_management_messaging_en <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** tb/smt_init_model.sv ***
/* initiator model for the management link: start, stop, byte write and
   byte read cycles. assumes a pull-up on sda and a passive target. */
`timescale 1ns/1ns
`default_nettype none
module smt_init_model (
  output logic o_scl,
  output logic o_sda_rel,
  input wire logic i_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda_rel = 1'b1;
  end
  // long low phase keeps data changes clear of the synced scl rise
  task bitc(input logic b, output logic r);
    #25 o_sda_rel = b;
    #25 o_scl = 1'b1;
    #27 r = i_sda;
    #3 o_scl = 1'b0;
  endtask
  task start_c;
    #40 o_sda_rel = 1'b1;
    #40 o_scl = 1'b1;
    #40 o_sda_rel = 1'b0;
    #40 o_scl = 1'b0;
  endtask
  task stop_c;
    #40 o_sda_rel = 1'b0;
    #40 o_scl = 1'b1;
    #40 o_sda_rel = 1'b1;
    #40;
  endtask
  task tx(input logic [7:0] v, inout logic [7:0] n);
    logic r;
    for (int i = 7; i >= 0; i--) bitc(v[i], r);
    bitc(1'b1, r);
    if (r === 1'b0) n++;
  endtask
  task wr(input logic [6:0] a, input logic [7:0] x, input logic [7:0] v,
          output logic [7:0] n);
    n = 8'h00;
    // calls start on a clock edge; step off it so no pin moves there
    #2;
    start_c;
    tx({a, 1'b0}, n);
    tx(x, n);
    tx(v, n);
    stop_c;
  endtask
  task rd(input logic [6:0] a, input logic [7:0] x, output logic [7:0] d,
          output logic [7:0] n);
    logic r;
    n = 8'h00;
    #2;
    start_c;
    tx({a, 1'b0}, n);
    tx(x, n);
    start_c;
    tx({a, 1'b1}, n);
    for (int i = 7; i >= 0; i--) bitc(1'b1, d[i]);
    bitc(1'b1, r);
    stop_c;
  endtask
endmodule
`default_nettype wire

// *** tb/smt_target_checker.sv ***
/* port checker for smt_target.
   assumes a bind onto smt_target, one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module smt_target_checker
  import smt_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_resume_well_reset_b,
  input wire logic o_sda_oe_b,
  input wire logic [2:0] i_power_state,
  input wire logic o_wake,
  input wire logic o_system_management_interrupt,
  input wire logic o_power_button_override_status,
  input wire logic o_power_down,
  input wire logic o_reset_port_write,
  input wire logic [3:0] o_reset_port_bits,
  input wire logic o_management_messaging_en,
  input wire logic o_watchdog_reload_command,
  input wire logic o_link_target_interrupt_status
);
  logic [2:0] age_r;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // cycles since resume reset low, saturating
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) age_r <= 3'h7;
    else if (!i_resume_well_reset_b) age_r <= 3'h0;
    else if (age_r != 3'h7) age_r <= age_r + 3'h1;
  end
  sequence s_sts_set;
    ##[0:1] o_power_button_override_status;
  endsequence
  chk_wake_when_asleep: assert property (
    o_wake |-> $past(i_power_state) != PWR_STATE_S0)
    else $error("wake in S0");
  chk_smi_when_awake: assert property (
    o_system_management_interrupt |-> $past(i_power_state) == PWR_STATE_S0)
    else $error("interrupt while asleep");
  chk_override_set: assert property (
    o_power_down |-> s_sts_set) else $error("override status not set");
  chk_override_sticky: assert property (
    o_power_button_override_status |=> o_power_button_override_status)
    else $error("override status lost");
  chk_port_bits: assert property (o_reset_port_write |-> ##[0:1]
    (o_reset_port_bits == RST_CTRL_SOFT ||
     o_reset_port_bits == RST_CTRL_HARD)) else $error("bad port bits");
  chk_link_in_s0: assert property (
    $rose(o_link_target_interrupt_status) |->
    $past(i_power_state) == PWR_STATE_S0) else $error("link status asleep");
  chk_msg_reenable: assert property (
    $rose(o_management_messaging_en) |-> age_r < 3'h6)
    else $error("messaging back without resume reset");
  chk_ack_release: assert property (
    $fell(o_sda_oe_b) |-> ##[1:100] o_sda_oe_b) else $error("sda held");
  chk_wd_single: assert property (
    o_watchdog_reload_command |=> !o_watchdog_reload_command)
    else $error("reload pulse too long");
endmodule
bind smt_target smt_target_checker u_smt_target_checker (
  .i_sys_clk, .i_rst_b, .i_resume_well_reset_b, .o_sda_oe_b,
  .i_power_state, .o_wake, .o_system_management_interrupt,
  .o_power_button_override_status, .o_power_down, .o_reset_port_write,
  .o_reset_port_bits, .o_management_messaging_en,
  .o_watchdog_reload_command, .o_link_target_interrupt_status);
`default_nettype wire

// *** tb/smt_target_tb_top.sv ***
/* bench for smt_target driven through the initiator model.
   assumes smt_init_model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module smt_target_tb_top;
  import smt_pkg::*;
  localparam logic [6:0] A = TARGET_ADDR_RESET;
  // seen bits: wake, smi, power down, reset write, reload, link command
  localparam logic [5:0] EXP [0:10] = '{6'h00, 6'h10, 6'h08, 6'h04,
    6'h04, 6'h00, 6'h02, 6'h00, 6'h01, 6'h00, 6'h00};
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic rwr_b = 1'b1;
  logic [2:0] pst = PWR_STATE_S0;
  logic [7:0] rdat = 8'h00;
  logic scl, rel, oe_b, wake, smi, pbos, pd, rpw, men, wd, lsts, lcmd;
  logic [7:0] ridx, lo, hi, n, d;
  logic [3:0] rpb;
  logic [5:0] seen = 6'h00;
  logic clr = 1'b0;
  int fail_count = 0;
  int checks = 0;
  wire logic sda = rel & oe_b;
  always #5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    seen <= clr ? 6'h00 : seen | {wake, smi, pd, rpw, wd, lcmd};
  end
  smt_target #(.TARGET_ADDR(A)) u_smt_target (.i_sys_clk, .i_rst_b,
    .i_resume_well_reset_b(rwr_b), .i_scl(scl), .i_sda(sda),
    .o_sda_oe_b(oe_b), .i_power_state(pst), .i_read_data(rdat),
    .o_read_index(ridx), .o_message_byte_low(lo),
    .o_message_byte_high(hi), .o_wake(wake),
    .o_system_management_interrupt(smi),
    .o_power_button_override_status(pbos), .o_power_down(pd),
    .o_reset_port_write(rpw), .o_reset_port_bits(rpb),
    .o_management_messaging_en(men), .o_watchdog_reload_command(wd),
    .o_link_target_interrupt_status(lsts),
    .o_link_target_interrupt_command(lcmd));
  smt_init_model u_smt_init_model (.o_scl(scl), .o_sda_rel(rel),
    .i_sda(sda));
  task cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task wr(input logic [6:0] a, input logic [7:0] x, input logic [7:0] v,
          input logic [7:0] en, input logic [5:0] es);
    @(posedge i_sys_clk) clr <= 1'b1;
    @(posedge i_sys_clk) clr <= 1'b0;
    u_smt_init_model.wr(a, x, v, n);
    repeat (10) @(posedge i_sys_clk);
    cmp(n, en);
    cmp({2'h0, seen}, {2'h0, es});
  endtask
  initial begin
    #200000;
    fail_count++;
    final_report;
  end
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    cmp({oe_b, men, pbos, lsts, 4'h0}, 8'hC0);
    cmp(lo, MSG_BYTE_RESET);
    cmp(hi, MSG_BYTE_RESET);
    $display("test reset done");
    pst <= 3'h3;
    wr(A, REG_MGMT_COMMAND, CMD_LINK_SMI, 8'h03, 6'h01);
    wr(A, REG_MGMT_COMMAND, CMD_WAKE_OR_SMI, 8'h03, 6'h20);
    cmp({7'h0, lsts}, 8'h00);
    $display("test asleep done");
    pst <= PWR_STATE_S0;
    for (int c = 0; c <= 10; c++) begin
      wr(A, REG_MGMT_COMMAND, (c == 10) ? 8'hFF : 8'(c), 8'h03,
         EXP[c]);
      if (c == 3) cmp({4'h0, rpb}, {4'h0, RST_CTRL_SOFT});
    end
    cmp({4'h0, rpb}, {4'h0, RST_CTRL_HARD});
    cmp({men, pbos, lsts, 5'h00}, 8'h60);
    $display("test commands done");
    wr(A, REG_MSG_BYTE_LOW, 8'h5A, 8'h03, 6'h00);
    wr(A, REG_MSG_BYTE_HIGH, 8'hC3, 8'h03, 6'h00);
    cmp(lo, 8'h5A);
    cmp(hi, 8'hC3);
    wr(A, REG_MSG_BYTE_LOW, 8'h3C, 8'h03, 6'h00);
    wr(A, 8'h02, 8'h01, 8'h03, 6'h00);
    wr(A, 8'h06, 8'h06, 8'h03, 6'h00);
    wr(A ^ 7'h01, REG_MGMT_COMMAND, CMD_WATCHDOG_RELOAD_COMMAND, 8'h00, 6'h00);
    cmp(lo, 8'h3C);
    cmp(hi, 8'hC3);
    $display("test messages done");
    rwr_b <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
    rwr_b <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    cmp({7'h0, men}, 8'h01);
    rdat <= 8'hA5;
    u_smt_init_model.rd(A, 8'h07, d, n);
    cmp(d, 8'hA5);
    cmp(n, 8'h03);
    cmp(ridx, 8'h07);
    $display("test read done");
    final_report;
  end
endmodule
`default_nettype wire
